// ---- include/tsr_cfg.svh ----
// register map, field positions, reset values and timing of the sensor serial block
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH
`define TSR_PTR_TEMP     3'h0
`define TSR_PTR_CFG      3'h1
`define TSR_PTR_HYST     3'h2
`define TSR_PTR_TRIP     3'h3
`define TSR_PTR_ONESHOT  3'h4
`define TSR_RST_TEMP     16'h0000
`define TSR_RST_CFG      8'h00
`define TSR_RST_HYST     16'h4b00
`define TSR_RST_TRIP     16'h5000
`define TSR_CFG_SHDN     0
`define TSR_CFG_MODE     1
`define TSR_CFG_POL      2
`define TSR_CFG_FQ_LO    3
`define TSR_CFG_FQ_HI    4
`define TSR_CFG_ONESHOT  5
`define TSR_CFG_WMASK    8'h3f
`define TSR_ADDR_FIXED   4'h9
`define TSR_UNMAPPED_RD  8'h00
`define TSR_CLK_NS       4
`define TSR_CONV_PER_NS  60000000
`define TSR_TIMEOUT_NS   22500000
`define TSR_CONV_PER_CYC (`TSR_CONV_PER_NS / `TSR_CLK_NS)
`define TSR_TIMEOUT_CYC  (`TSR_TIMEOUT_NS / `TSR_CLK_NS)
`define TSR_CONV_BUSY_CYC 16
`endif

// ---- include/tsr_pkg.sv ----
// types shared by the sensor serial block
package tsr_pkg;
	typedef logic [11:0] tsr_code_t;
	typedef logic [2:0]  tsr_ptr_t;
	typedef enum logic [2:0] {
		TSR_IDLE = 3'b000,
		TSR_ADDR = 3'b001,
		TSR_ACK  = 3'b010,
		TSR_WR   = 3'b011,
		TSR_RD   = 3'b100,
		TSR_RACK = 3'b101,
		TSR_WAIT = 3'b110
	} tsr_state_t;
endpackage

// ---- rtl/tsr_sync.sv ----
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module tsr_sync #(
	parameter int W = 5
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] pin_in,
	input  wire logic [W-1:0] rst_val,
	output var  logic [W-1:0] pin_out
);
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					ff1_r[i] <= 1'b1;
					ff2_r[i] <= 1'b1;
					ff3_r[i] <= 1'b1;
					pin_out[i] <= 1'b1;
				end else begin
					ff1_r[i] <= pin_in[i];
					ff2_r[i] <= ff1_r[i];
					ff3_r[i] <= ff2_r[i];
					if (ff2_r[i] == ff3_r[i]) begin
						pin_out[i] <= ff3_r[i];
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- rtl/tsr_top.sv ----
// serial slave and register bank of the temperature sensor
`include "tsr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tsr_top #(
	parameter int CONV_PER_CYC = `TSR_CONV_PER_CYC,
	parameter int TIMEOUT_CYC  = `TSR_TIMEOUT_CYC
) (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output var  logic               sda_out,
	output var  logic               sda_oe,
	input  wire logic               addr_select_pin_2,
	input  wire logic               addr_select_pin_1,
	input  wire logic               addr_select_pin_0,
	input  wire tsr_pkg::tsr_code_t temp_code,
	output var  logic               over_temp_output,
	output var  logic               conv_busy
);
	import tsr_pkg::*;

	localparam int OS_MAX = 2 * `TSR_CONV_BUSY_CYC + 6;

	logic [4:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic [2:0]  asel_s;
	logic        scl_q;
	logic        sda_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_ev;
	logic        stop_ev;
	tsr_state_t  state_r;
	logic [3:0]  bitcnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  tx_r;
	logic        rsel_r;
	logic [1:0]  wcnt_r;
	logic        rw_r;
	logic        drv_r;
	logic        addr_match;
	logic        addr_done;
	logic        wr_done;
	logic        rd_ack;
	logic [7:0]  rd_byte;
	tsr_ptr_t    ptr_r;
	logic [7:0]  cfg_r;
	logic [15:0] hyst_r;
	logic [15:0] trip_r;
	logic [15:0] temp_r;
	logic [7:0]  stage_r;
	logic        os_wr;
	logic        os_pend_r;
	logic [23:0] to_cnt_r;
	logic        to_hit;
	logic [23:0] per_cnt_r;
	logic [7:0]  busy_cnt_r;
	logic        conv_start;
	logic        conv_done;
	logic [15:0] temp_new;
	logic        fault;
	logic        below_hyst;
	logic [2:0]  fcnt_r;
	logic [2:0]  fcnt_inc;
	logic [2:0]  fneed;
	logic        trip_now;
	logic        cmp_r;
	logic        int_r;
	logic        active;
	logic        cont_mode;

	// pins cross into clk through three flops and a filtered output flop
	tsr_sync #(.W(5)) u_sync (
		.clk     (clk),
		.reset   (reset),
		.pin_in  ({scl_in, sda_in, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0}),
		.rst_val (5'h1f),
		.pin_out (pins_s)
	);
	assign scl_s  = pins_s[4];
	assign sda_s  = pins_s[3];
	assign asel_s = pins_s[2:0];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
	assign addr_match = (shift_r[7:1] == {`TSR_ADDR_FIXED, asel_s});
	assign addr_done  = (state_r == TSR_ADDR) && scl_fall && (bitcnt_r == 4'h8);
	assign wr_done    = (state_r == TSR_WR) && scl_fall && (bitcnt_r == 4'h8);
	assign rd_ack     = addr_done && addr_match && shift_r[0];

	// read byte mux: upper byte first, lower second
	always_comb begin
		rd_byte = `TSR_UNMAPPED_RD;
		unique case (ptr_r)
			`TSR_PTR_TEMP: rd_byte = rsel_r ? temp_r[7:0] : temp_r[15:8];
			`TSR_PTR_CFG:  rd_byte = cfg_r;
			`TSR_PTR_HYST: rd_byte = rsel_r ? hyst_r[7:0] : hyst_r[15:8];
			`TSR_PTR_TRIP: rd_byte = rsel_r ? trip_r[7:0] : trip_r[15:8];
			default:       rd_byte = `TSR_UNMAPPED_RD;
		endcase
	end

	// serial slave state machine
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r  <= TSR_IDLE;
			bitcnt_r <= 4'h0;
			shift_r  <= 8'h00;
			tx_r     <= 8'h00;
			rsel_r   <= 1'b0;
			wcnt_r   <= 2'h0;
			rw_r     <= 1'b0;
			drv_r    <= 1'b0;
		end else if (to_hit) begin
			state_r <= TSR_IDLE;
			drv_r   <= 1'b0;
		end else if (start_ev) begin
			state_r  <= TSR_ADDR;
			bitcnt_r <= 4'h0;
			rsel_r   <= 1'b0;
			wcnt_r   <= 2'h0;
			drv_r    <= 1'b0;
		end else if (stop_ev) begin
			state_r <= TSR_IDLE;
			drv_r   <= 1'b0;
		end else begin
			unique case (state_r)
				TSR_IDLE: begin
					drv_r <= 1'b0;
				end
				TSR_ADDR: begin
					if (scl_rise) begin
						shift_r  <= {shift_r[6:0], sda_s};
						bitcnt_r <= bitcnt_r + 4'h1;
					end
					if (addr_done) begin
						if (addr_match) begin
							state_r <= TSR_ACK;
							drv_r   <= 1'b1;
							rw_r    <= shift_r[0];
						end else begin
							state_r <= TSR_WAIT;
						end
					end
				end
				TSR_ACK: begin
					if (scl_fall) begin
						bitcnt_r <= 4'h0;
						if (rw_r) begin
							state_r <= TSR_RD;
							tx_r    <= rd_byte;
							drv_r   <= ~rd_byte[7];
							rsel_r  <= ~rsel_r;
						end else begin
							state_r <= TSR_WR;
							drv_r   <= 1'b0;
						end
					end
				end
				TSR_WR: begin
					if (scl_rise) begin
						shift_r  <= {shift_r[6:0], sda_s};
						bitcnt_r <= bitcnt_r + 4'h1;
					end
					if (wr_done) begin
						state_r <= TSR_ACK;
						drv_r   <= 1'b1;
						if (wcnt_r != 2'h3) begin
							wcnt_r <= wcnt_r + 2'h1;
						end
					end
				end
				TSR_RD: begin
					if (scl_fall) begin
						bitcnt_r <= bitcnt_r + 4'h1;
						if (bitcnt_r == 4'h7) begin
							state_r <= TSR_RACK;
							drv_r   <= 1'b0;
						end else begin
							tx_r  <= {tx_r[6:0], 1'b0};
							drv_r <= ~tx_r[6];
						end
					end
				end
				TSR_RACK: begin
					if (scl_rise && sda_s) begin
						state_r <= TSR_WAIT;
					end else if (scl_fall) begin
						state_r  <= TSR_RD;
						bitcnt_r <= 4'h0;
						tx_r     <= rd_byte;
						drv_r    <= ~rd_byte[7];
						rsel_r   <= ~rsel_r;
					end
				end
				TSR_WAIT: begin
					drv_r <= 1'b0;
				end
				default: begin
					state_r <= TSR_IDLE;
					drv_r   <= 1'b0;
				end
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = drv_r;

	// register writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ptr_r   <= `TSR_PTR_TEMP;
			cfg_r   <= `TSR_RST_CFG;
			hyst_r  <= `TSR_RST_HYST;
			trip_r  <= `TSR_RST_TRIP;
			stage_r <= 8'h00;
		end else if (wr_done) begin
			if (wcnt_r == 2'h0) begin
				ptr_r <= shift_r[2:0];
			end else if (wcnt_r == 2'h1) begin
				stage_r <= shift_r;
				if (ptr_r == `TSR_PTR_CFG) begin
					cfg_r <= shift_r & `TSR_CFG_WMASK;
				end
			end else if (wcnt_r == 2'h2) begin
				if (ptr_r == `TSR_PTR_HYST) begin
					hyst_r <= {stage_r, shift_r[7:4], 4'h0};
				end
				if (ptr_r == `TSR_PTR_TRIP) begin
					trip_r <= {stage_r, shift_r[7:4], 4'h0};
				end
			end
		end
	end

	assign os_wr = wr_done && (wcnt_r == 2'h1) && (ptr_r == `TSR_PTR_ONESHOT);

	// bus timeout, only while data is low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			to_cnt_r <= 24'h0;
		end else if (sda_s || (state_r == TSR_IDLE) || to_hit) begin
			to_cnt_r <= 24'h0;
		end else begin
			to_cnt_r <= to_cnt_r + 24'h1;
		end
	end
	assign to_hit = (to_cnt_r == 24'(TIMEOUT_CYC - 1));

	// conversion scheduling
	assign cont_mode  = ~cfg_r[`TSR_CFG_SHDN] & ~cfg_r[`TSR_CFG_ONESHOT];
	assign conv_busy  = (busy_cnt_r != 8'h0);
	assign conv_start = ~conv_busy &&
		((cont_mode && (per_cnt_r == 24'h0)) || os_pend_r);
	assign conv_done  = (busy_cnt_r == 8'h1);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			per_cnt_r <= 24'h0;
		end else if (!cont_mode) begin
			per_cnt_r <= 24'h0;
		end else if (per_cnt_r == 24'h0) begin
			if (!conv_busy) begin
				per_cnt_r <= 24'(CONV_PER_CYC - 1);
			end
		end else begin
			per_cnt_r <= per_cnt_r - 24'h1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			os_pend_r <= 1'b0;
		end else if (os_wr && (cfg_r[`TSR_CFG_ONESHOT] || cfg_r[`TSR_CFG_SHDN])) begin
			os_pend_r <= 1'b1;
		end else if (conv_start) begin
			os_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy_cnt_r <= 8'h0;
		end else if (conv_start) begin
			busy_cnt_r <= 8'(`TSR_CONV_BUSY_CYC);
		end else if (conv_busy) begin
			busy_cnt_r <= busy_cnt_r - 8'h1;
		end
	end

	assign temp_new = {temp_code, 4'h0};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			temp_r <= `TSR_RST_TEMP;
		end else if (conv_done) begin
			temp_r <= temp_new;
		end
	end

	// fault queue and over-temperature output
	assign fault      = ($signed(temp_new) >= $signed(trip_r));
	assign below_hyst = ($signed(temp_new) < $signed(hyst_r));
	assign fcnt_inc   = (fcnt_r == 3'h7) ? 3'h7 : fcnt_r + 3'h1;
	always_comb begin
		unique case (cfg_r[`TSR_CFG_FQ_HI:`TSR_CFG_FQ_LO])
			2'b00: fneed = 3'h1;
			2'b01: fneed = 3'h2;
			2'b10: fneed = 3'h4;
			2'b11: fneed = 3'h6;
		endcase
	end
	assign trip_now = conv_done && fault && (fcnt_inc >= fneed);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fcnt_r <= 3'h0;
		end else if (conv_done) begin
			fcnt_r <= fault ? fcnt_inc : 3'h0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmp_r <= 1'b0;
		end else if (trip_now) begin
			cmp_r <= 1'b1;
		end else if (conv_done && below_hyst) begin
			cmp_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			int_r <= 1'b0;
		end else if (trip_now) begin
			int_r <= 1'b1;
		end else if (rd_ack) begin
			int_r <= 1'b0;
		end
	end

	assign active = cfg_r[`TSR_CFG_MODE] ? int_r : cmp_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			over_temp_output <= 1'b1;
		end else begin
			over_temp_output <= cfg_r[`TSR_CFG_POL] ? active : ~active;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_TEMP_HOLD: assert property (!conv_done |=> $stable(temp_r))
		else $error("temperature changed outside conversion end");
	AST_TEMP_RO: assert property (wr_done && ptr_r == `TSR_PTR_TEMP && !conv_done |=> $stable(temp_r))
		else $error("write changed temperature register");
	AST_ADDR_ACK: assert property (addr_done && addr_match |=> sda_oe && state_r == TSR_ACK)
		else $error("matching address not acknowledged");
	AST_ADDR_MISS: assert property (addr_done && !addr_match && !to_hit |=> !sda_oe)
		else $error("foreign address acknowledged");
	AST_TIMEOUT: assert property (to_hit |=> state_r == TSR_IDLE && !sda_oe)
		else $error("timeout did not release data line");
	AST_TO_HIGH: assert property (sda_s |=> to_cnt_r == 24'h0)
		else $error("timeout ran while data high");
	AST_SHDN: assert property (cfg_r[`TSR_CFG_SHDN] && !os_pend_r |-> !conv_start)
		else $error("conversion started in shutdown");
	AST_ONESHOT: assert property (os_wr && cfg_r[`TSR_CFG_ONESHOT] |-> ##[1:OS_MAX] conv_done)
		else $error("one-shot write gave no conversion");
	AST_FQ_RESTART: assert property (conv_done && !fault |=> fcnt_r == 3'h0)
		else $error("fault count not restarted");
	AST_INT_CLR: assert property (cfg_r[`TSR_CFG_MODE] && rd_ack && !trip_now |=> ##1
		over_temp_output == !cfg_r[`TSR_CFG_POL])
		else $error("read did not clear latched output");
	AST_POL: assert property (##1 over_temp_output ==
		($past(cfg_r[`TSR_CFG_POL]) ? $past(active) : !$past(active)))
		else $error("output polarity wrong");

	COV_READ: cover property (rd_ack ##[1:1000] state_r == TSR_RACK);
	COV_WRITE: cover property (wr_done && wcnt_r == 2'h2);
	COV_CONV: cover property (conv_done ##1 active);
	COV_TIMEOUT: cover property (to_hit);
endmodule
`default_nettype wire

// ---- verif/tsr_bus_master.sv ----
// serial bus master model for the sensor block
`timescale 1ns/1ns
`default_nettype none
module tsr_bus_master (
	input  wire logic clk,
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// data moves while clock low, sampled at end of high phase
	task automatic xfer_bit(input logic drive_low, output logic seen);
		wait_clk(3);
		sda_low <= drive_low;
		wait_clk(8);
		scl <= 1'b1;
		wait_clk(10);
		seen = sda;
		scl <= 1'b0;
	endtask
	task automatic start_cond();
		wait_clk(3);
		sda_low <= 1'b0;
		wait_clk(8);
		scl <= 1'b1;
		wait_clk(10);
		sda_low <= 1'b1;
		wait_clk(10);
		scl <= 1'b0;
	endtask
	task automatic stop_cond();
		wait_clk(3);
		sda_low <= 1'b1;
		wait_clk(8);
		scl <= 1'b1;
		wait_clk(10);
		sda_low <= 1'b0;
		wait_clk(10);
	endtask
	// msb first, ninth clock left to the receiver
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) xfer_bit(!b[i], s);
		xfer_bit(1'b0, s);
		ack = !s;
	endtask
	// upper byte expected first; nack ends the read
	task automatic recv_byte(input logic give_ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b0, s);
			d[i] = s;
		end
		xfer_bit(give_ack, s);
	endtask
	task automatic hold(input logic low, input int n);
		wait_clk(3);
		sda_low <= low;
		wait_clk(n);
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_temp_sensor_serial_regs.sv ----
// testbench of the sensor serial block
`include "tsr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_temp_sensor_serial_regs;
	import tsr_pkg::*;
	logic      clk, reset, scl, sda_low, sda_oe, sda_out, ots, busy, busy_d, a;
	logic [2:0] strap;
	tsr_code_t temp_code;
	int        fails, cmp_count, ends, e0;
	int        faults [4] = '{1, 2, 4, 6};
	wire       sda = !(sda_oe || sda_low);
	tsr_top #(.CONV_PER_CYC(400), .TIMEOUT_CYC(600)) tsr_top_inst (
		.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_select_pin_2(strap[2]), .addr_select_pin_1(strap[1]),
		.addr_select_pin_0(strap[0]), .temp_code(temp_code), .over_temp_output(ots),
		.conv_busy(busy));
	tsr_bus_master tsr_bus_master_inst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		busy_d <= busy;
		if (busy_d === 1'b1 && busy === 1'b0) ends <= ends + 1;
	end
	task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic check_bit(input string nm, input logic e, input logic g);
		check_val(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic wr_reg(input logic [2:0] p, input int n, input logic [15:0] v);
		tsr_bus_master_inst.start_cond();
		tsr_bus_master_inst.send_byte({`TSR_ADDR_FIXED, strap, 1'b0}, a);
		check_bit("addr ack", 1'b1, a);
		tsr_bus_master_inst.send_byte({5'h00, p}, a);
		check_bit("ptr ack", 1'b1, a);
		for (int i = 0; i < n; i++) begin
			tsr_bus_master_inst.send_byte(i ? v[7:0] : v[15:8], a);
			check_bit("data ack", 1'b1, a);
		end
		tsr_bus_master_inst.stop_cond();
	endtask
	task automatic rd_chk(input logic [2:0] p, input string nm, input logic [15:0] e);
		logic [15:0] v;
		wr_reg(p, 0, 16'h0000);
		tsr_bus_master_inst.start_cond();
		tsr_bus_master_inst.send_byte({`TSR_ADDR_FIXED, strap, 1'b1}, a);
		check_bit("read ack", 1'b1, a);
		tsr_bus_master_inst.recv_byte(1'b1, v[15:8]);
		tsr_bus_master_inst.recv_byte(1'b0, v[7:0]);
		tsr_bus_master_inst.stop_cond();
		check_val(nm, e, v);
	endtask
	task automatic wait_conv(input int n);
		int t;
		t = 0;
		e0 = ends + n;
		while (ends < e0 && t < 2000 * n) begin
			@(posedge clk);
			t++;
		end
		check_bit("conversion done", 1'b1, ends >= e0);
		repeat (3) @(posedge clk);
	endtask
	task automatic no_conv(input string nm);
		e0 = ends;
		repeat (1000) @(posedge clk);
		check_val(nm, e0[15:0], ends[15:0]);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		$display("[FAIL] watchdog expected finish seen timeout");
		stop_test();
	end
	initial begin
		reset = 1'b1;
		strap = 3'h5;
		temp_code = 12'h190;
		fails = 0;
		cmp_count = 0;
		ends = 0;
		busy_d = 1'b0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (10) @(posedge clk);
		check_bit("idle output", 1'b1, ots);
		check_bit("data value", 1'b0, sda_out);
		rd_chk(`TSR_PTR_HYST, "hyst", `TSR_RST_HYST);
		rd_chk(`TSR_PTR_TRIP, "trip", `TSR_RST_TRIP);
		rd_chk(`TSR_PTR_CFG, "cfg", {2{`TSR_RST_CFG}});
		rd_chk(`TSR_PTR_TEMP, "temp", {temp_code, 4'h0});
		wr_reg(`TSR_PTR_TEMP, 2, 16'hffff);
		rd_chk(`TSR_PTR_TEMP, "temp ro", 16'h1900);
		wr_reg(`TSR_PTR_TRIP, 2, 16'h55ab);
		rd_chk(`TSR_PTR_TRIP, "trip wr", 16'h55a0);
		rd_chk(3'h6, "unmapped", {2{`TSR_UNMAPPED_RD}});
		tsr_bus_master_inst.start_cond();
		tsr_bus_master_inst.send_byte({`TSR_ADDR_FIXED, ~strap, 1'b1}, a);
		tsr_bus_master_inst.stop_cond();
		check_bit("foreign ack", 1'b0, a);
		@(posedge clk) strap <= 3'h2;
		repeat (10) @(posedge clk);
		rd_chk(`TSR_PTR_HYST, "new addr", `TSR_RST_HYST);
		wr_reg(`TSR_PTR_TRIP, 2, 16'h1900);
		wr_reg(`TSR_PTR_HYST, 2, 16'h1000);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) temp_code <= 12'h000;
			wr_reg(`TSR_PTR_CFG, 2, {3'h0, k[1:0], 3'h0, 8'hff});
			wait_conv(1);
			check_bit("cleared", 1'b1, ots);
			@(posedge clk) temp_code <= 12'h190;
			wait_conv(faults[k] - 1);
			check_bit("below count", 1'b1, ots);
			wait_conv(1);
			check_bit("tripped", 1'b0, ots);
		end
		wr_reg(`TSR_PTR_CFG, 1, 16'h1c00);
		wait_conv(1);
		check_bit("high active", 1'b1, ots);
		wr_reg(`TSR_PTR_CFG, 1, 16'h0200);
		wait_conv(1);
		check_bit("latched set", 1'b0, ots);
		wr_reg(`TSR_PTR_CFG, 1, 16'h0300);
		rd_chk(`TSR_PTR_CFG, "cfg rd", 16'h0303);
		check_bit("read clears", 1'b1, ots);
		no_conv("shutdown");
		wr_reg(`TSR_PTR_CFG, 1, 16'h2200);
		no_conv("one-shot idle");
		e0 = ends;
		wr_reg(`TSR_PTR_ONESHOT, 1, 16'h0000);
		repeat (3) @(posedge clk);
		check_val("one-shot count", e0[15:0] + 16'h0001, ends[15:0]);
		check_bit("reassert", 1'b0, ots);
		no_conv("single");
		tsr_bus_master_inst.start_cond();
		tsr_bus_master_inst.send_byte({`TSR_ADDR_FIXED, strap, 1'b0}, a);
		tsr_bus_master_inst.hold(1'b0, 800);
		tsr_bus_master_inst.send_byte({5'h00, `TSR_PTR_ONESHOT}, a);
		check_bit("high idle kept", 1'b1, a);
		tsr_bus_master_inst.stop_cond();
		tsr_bus_master_inst.start_cond();
		tsr_bus_master_inst.send_byte({`TSR_ADDR_FIXED, strap, 1'b1}, a);
		tsr_bus_master_inst.hold(1'b0, 800);
		check_bit("released", 1'b0, sda_oe);
		tsr_bus_master_inst.stop_cond();
		rd_chk(`TSR_PTR_HYST, "after timeout", 16'h1000);
		stop_test();
	end
endmodule
`default_nettype wire
